// file: dv/emfs_checker.sv
// concurrent checks on the supervision and register ports of emfs_top
// assumes one clock domain and the synchronous active-low reset
module emfs_checker
    import emfs_pkg::*;
#(
    parameter int RESTART_CYCLES = 4,
    parameter int BLINK_CYCLES = 3
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire emfs_pkg::emfs_req_t i_req,
    input wire logic [15:0] o_rdata,
    input wire logic i_fault,
    input wire logic [7:0] i_fault_code,
    input wire logic i_startup,
    input wire logic [4:0] i_contact_req,
    input wire logic o_restart,
    input wire logic o_ready_led,
    input wire logic o_supv_contact,
    input wire logic [4:0] o_contact,
    input wire logic o_settings_zero,
    input wire emfs_pkg::emfs_disp_t o_disp_src,
    input wire logic [7:0] o_disp_code
);
    localparam int RMAX = RESTART_CYCLES + 4; // restart wait with pipeline slack
    localparam int BMAX = BLINK_CYCLES + 1; // blink half period with slack
    logic clr_msg; // software asks to clear the message
    assign clr_msg = i_req.wr && i_req.addr == ADDR_CONTROL && i_req.wdata[CTL_CLEAR_MSG];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // persistent fault seen on two edges in a row
    sequence s_persist;
        o_supv_contact ##1 o_supv_contact;
    endsequence
    AST_RESTART_FIRST: assert property ($rose(i_fault) && !o_supv_contact |-> ##[1:3] o_restart)
        else $error("restart not attempted");
    AST_ESCALATE: assert property (o_restart && i_fault |-> ##[1:RMAX] (o_supv_contact || !o_restart))
        else $error("persistent fault not escalated");
    AST_BLINK: assert property (o_supv_contact |-> ##[1:BMAX] (o_ready_led != $past(o_ready_led) || !o_supv_contact))
        else $error("ready light not blinking");
    AST_LED_NORMAL: assert property (!o_supv_contact && $past(!o_supv_contact) && $past(i_rstn)
        && $past(i_rstn, 2) |-> o_ready_led)
        else $error("ready light not steady");
    AST_LOCKED: assert property (s_persist |-> o_contact == 5'h00)
        else $error("contacts not locked");
    AST_FOLLOW: assert property (!o_supv_contact && $past(!o_supv_contact) && $past(i_rstn)
        |-> o_contact == $past(i_contact_req))
        else $error("contacts not following requests");
    AST_DISP_FAULT: assert property (s_persist |-> o_disp_src == EMFS_DISP_FAULT)
        else $error("fault not shown first");
    AST_LIVE_CODE: assert property (s_persist |-> o_disp_code == $past(i_fault_code)
        || o_disp_code == $past(i_fault_code, 2))
        else $error("wrong fault code shown");
    AST_MSG_HOLD: assert property (o_disp_src == EMFS_DISP_FAULT && !clr_msg && !i_startup
        && !$past(clr_msg) && !$past(i_startup) |=> o_disp_src == EMFS_DISP_FAULT)
        else $error("fault message lost");
    AST_NO_CLEAR: assert property (o_supv_contact && i_fault && $past(i_fault) && clr_msg
        && !i_startup |=> o_disp_src == EMFS_DISP_FAULT)
        else $error("message cleared while blinking");
    AST_SETTINGS_ZERO: assert property ($past(i_rstn) |-> o_settings_zero == $past(i_fault
        && i_fault_code >= 8'h33 && i_fault_code <= 8'h38 && i_fault_code != 8'h37))
        else $error("settings zero flag wrong");
    AST_RDATA_IDLE: assert property (!$past(i_req.rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read slot");
endmodule
bind emfs_top emfs_checker #(.RESTART_CYCLES(RESTART_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) u_chk (
    .i_mclk, .i_rstn, .i_req, .o_rdata, .i_fault, .i_fault_code, .i_startup, .i_contact_req,
    .o_restart, .o_ready_led, .o_supv_contact, .o_contact, .o_settings_zero, .o_disp_src,
    .o_disp_code
);

// file: dv/emfs_plant.sv
// far-side model: fault source and protection logic feeding the block
// assumes bench commands change right after a rising edge of i_mclk
module emfs_plant (
    // clock
    input wire logic i_mclk,
    // commands from the bench
    input wire logic i_set_fault,
    input wire logic [7:0] i_set_code,
    // lines into the block
    output logic o_fault,
    output logic [7:0] o_code,
    output logic [4:0] o_contact_req = 5'h00
);
    // fault level and code launched from a flop like a real source
    always_ff @(posedge i_mclk) begin
        o_fault <= i_set_fault;
        o_code <= i_set_code;
    end
    // requests change every cycle so a stale contact value never matches
    always_ff @(posedge i_mclk) begin
        o_contact_req <= o_contact_req + 5'h01;
    end
endmodule

// file: dv/tb_emfs_top.sv
// self-checking bench for emfs_top with the fault plant model
// assumes short restart and blink counts set by parameter
module tb_emfs_top;
    timeunit 1ns;
    timeprecision 1ps;
    import emfs_pkg::*;
    localparam int RC = 4; // shortened restart confirm time
    localparam int BC = 3; // shortened blink half period
    localparam logic [7:0] CODES [14] = '{8'h04, 8'h08, 8'h09, 8'h0C, 8'h15, 8'h1E, 8'h3B,
        8'h33, 8'h37, 8'h52, 8'h5F, 8'h68, 8'hDF, 8'hFD};
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    emfs_req_t req = '0;
    logic [9:0] oe = '0;
    logic [9:0] de = '0;
    logic [7:0] te = '0;
    logic warn = 1'b0;
    logic st = 1'b0;
    logic f_set = 1'b0;
    logic [7:0] f_code = 8'h04;
    logic flt, rst_o, led, supv, sz;
    logic [7:0] fcd, dcode;
    logic [4:0] creq, cont;
    logic [15:0] rdata;
    logic [27:0] evt;
    emfs_disp_t dsrc;
    int num_errors = 0;
    int n_tests = 0;
    // 250 MHz clock
    always #2 i_mclk = ~i_mclk;
    emfs_plant u_plant (.i_mclk, .i_set_fault(f_set), .i_set_code(f_code), .o_fault(flt),
        .o_code(fcd), .o_contact_req(creq));
    emfs_top #(.RESTART_CYCLES(RC), .BLINK_CYCLES(BC)) u_dut (.i_mclk, .i_rstn, .i_req(req),
        .o_rdata(rdata), .i_out_evt(oe), .i_din_evt(de), .i_thm_evt(te), .i_fault(flt),
        .i_fault_code(fcd), .i_warning(warn), .i_startup(st), .i_contact_req(creq),
        .o_restart(rst_o), .o_ready_led(led), .o_supv_contact(supv), .o_contact(cont),
        .o_settings_zero(sz), .o_disp_src(dsrc), .o_disp_code(dcode), .o_evt(evt));
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_mclk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge i_mclk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_mclk);
        req.rd <= 1'b0;
        #1 chk("rdata", 28'(e), 28'(rdata));
    endtask
    // pulse raw events, compare the sticky report, then clear it
    task automatic t_evt(input logic [27:0] raw, input logic [27:0] e);
        @(posedge i_mclk);
        {te, de, oe} <= raw;
        @(posedge i_mclk);
        {te, de, oe} <= '0;
        cyc(2);
        chk("evt", e, evt);
        wr(ADDR_CONTROL, 16'h0002);
        cyc(2);
        chk("evt_clr", '0, evt);
    endtask
    // raise a fault and wait, bounded, for escalation
    task automatic raise(input logic [7:0] c);
        int i;
        @(posedge i_mclk);
        f_code <= c;
        f_set <= 1'b1;
        for (i = 0; i < 40 && supv !== 1'b1; i++) cyc(1);
        if (supv !== 1'b1) begin
            num_errors++;
            $display("MISMATCH supv expected 1 seen %b", supv);
            close_out();
        end
        cyc(3);
    endtask
    task automatic t_regs;
        rd(ADDR_OUT_MASK, 16'h0003);
        rd(ADDR_DIN_MASK, 16'h0000);
        rd(ADDR_THM_MASK, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(ADDR_THM_MASK, 16'h0055);
        rd(ADDR_THM_MASK, 16'h0055);
        $display("test regs done");
    endtask
    task automatic t_events;
        t_evt({8'hFF, 10'h3FF, 10'h3FF}, {8'h55, 10'h000, 10'h003});
        wr(ADDR_OUT_MASK, 16'h0300);
        wr(ADDR_DIN_MASK, 16'h0201);
        wr(ADDR_THM_MASK, 16'h00AA);
        t_evt({8'hFF, 10'h3FF, 10'h3FF}, {8'hAA, 10'h201, 10'h300});
        t_evt({8'h0F, 10'h001, 10'h0FF}, {8'h0A, 10'h001, 10'h000});
        $display("test events done");
    endtask
    // fault shorter than the restart window never escalates
    task automatic t_restart;
        int i;
        logic seen;
        seen = 1'b0;
        @(posedge i_mclk);
        f_set <= 1'b1;
        repeat (2) @(posedge i_mclk);
        f_set <= 1'b0;
        for (i = 0; i < 12; i++) begin
            cyc(1);
            seen = seen | rst_o;
            chk("supv", '0, 28'(supv));
        end
        chk("restart", 28'(1'b1), 28'(seen));
        $display("test restart done");
    endtask
    task automatic t_persist;
        int i, tg;
        logic l;
        raise(8'h04);
        chk("contact", '0, 28'(cont));
        @(posedge i_mclk);
        warn <= 1'b1;
        cyc(2);
        chk("src", 28'(EMFS_DISP_FAULT), 28'(dsrc));
        tg = 0;
        l = led;
        for (i = 0; i < 4 * BC; i++) begin
            cyc(1);
            tg += int'(led !== l);
            l = led;
        end
        chk("blink", 28'(1'b1), 28'(tg >= 3));
        foreach (CODES[k]) begin
            @(posedge i_mclk);
            f_code <= CODES[k];
            cyc(3);
            chk("code", 28'(CODES[k]), 28'(dcode));
            chk("zero", 28'(CODES[k] inside {[8'h33:8'h36], 8'h38}), 28'(sz));
        end
        wr(ADDR_CONTROL, 16'h0001);
        cyc(2);
        chk("src", 28'(EMFS_DISP_FAULT), 28'(dsrc));
        @(posedge i_mclk);
        f_set <= 1'b0;
        cyc(4);
        chk("led", 28'(1'b1), 28'(led));
        chk("src", 28'(EMFS_DISP_FAULT), 28'(dsrc));
        chk("contact", 28'(creq - 5'h01), 28'(cont));
        wr(ADDR_CONTROL, 16'h0001);
        cyc(2);
        chk("src", 28'(EMFS_DISP_WARN), 28'(dsrc));
        @(posedge i_mclk);
        warn <= 1'b0;
        $display("test persist done");
    endtask
    // motor start-up clears the kept message
    task automatic t_startup;
        raise(8'h5A);
        chk("code", 28'(8'h5A), 28'(dcode));
        @(posedge i_mclk);
        f_set <= 1'b0;
        cyc(4);
        chk("src", 28'(EMFS_DISP_FAULT), 28'(dsrc));
        rd(ADDR_FAULT_CODE, 16'h005A);
        @(posedge i_mclk);
        st <= 1'b1;
        @(posedge i_mclk);
        st <= 1'b0;
        cyc(2);
        chk("src", 28'(EMFS_DISP_NONE), 28'(dsrc));
        $display("test startup done");
    endtask
    // reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rstn <= 1'b1;
        t_regs();
        t_events();
        t_restart();
        t_persist();
        t_startup();
        close_out();
    end
endmodule

// file: src/emfs_pkg.sv
// package for the event mask and fault supervision block
// assumes a single clock domain; shared by the block and its bench
package emfs_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_OUT_MASK = 4'h0;
    localparam logic [3:0] ADDR_DIN_MASK = 4'h1;
    localparam logic [3:0] ADDR_THM_MASK = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_EVENTS = 4'h4;
    localparam logic [3:0] ADDR_CONTROL = 4'h5;
    localparam logic [3:0] ADDR_FAULT_CODE = 4'h6;
    // mask reset values
    localparam logic [9:0] OUT_MASK_RST = 10'h003;
    localparam logic [9:0] DIN_MASK_RST = 10'h000;
    localparam logic [7:0] THM_MASK_RST = 8'h00;
    // thermal mask bit positions
    localparam int THM_A_ALARM_ON = 0;
    localparam int THM_A_ALARM_OFF = 1;
    localparam int THM_A_TRIP_ON = 2;
    localparam int THM_A_TRIP_OFF = 3;
    localparam int THM_B_ALARM_ON = 4;
    localparam int THM_B_ALARM_OFF = 5;
    localparam int THM_B_TRIP_ON = 6;
    localparam int THM_B_TRIP_OFF = 7;
    // control register bit positions
    localparam int CTL_CLEAR_MSG = 0;
    localparam int CTL_CLEAR_EVT = 1;
    // status register bit positions
    localparam int STS_FAULT_ACTIVE = 0;
    localparam int STS_BLINK = 1;
    localparam int STS_MSG_SHOWN = 2;
    localparam int STS_RESTARTING = 3;
    localparam int STS_WARNING = 4;
    localparam int STS_SETTINGS_ZERO = 5;
    // fault codes
    localparam logic [7:0] FC_NONE = 8'h00;
    localparam logic [7:0] FC_RELAY_BASE = 8'h04;
    localparam logic [7:0] FC_ENABLE_SIG = 8'h09;
    localparam logic [7:0] FC_FEEDBACK = 8'h0A;
    localparam logic [7:0] FC_ENABLE_ALT = 8'h0B;
    localparam logic [7:0] FC_RELAY_ALT = 8'h0C;
    localparam logic [7:0] FC_DIP_A = 8'h14;
    localparam logic [7:0] FC_DIP_B = 8'h15;
    localparam logic [7:0] FC_PROG_MEM = 8'h1E;
    localparam logic [7:0] FC_WORK_A = 8'h32;
    localparam logic [7:0] FC_WORK_B = 8'h3B;
    localparam logic [7:0] FC_PARAM_LO = 8'h33;
    localparam logic [7:0] FC_PARAM_CAL = 8'h37;
    localparam logic [7:0] FC_PARAM_HI = 8'h38;
    localparam logic [7:0] FC_SENS_FAULTY = 8'h4B;
    localparam logic [7:0] FC_SENS_MISSING = 8'h50;
    localparam logic [7:0] FC_SENS_UNKNOWN = 8'h51;
    localparam logic [7:0] FC_SENS_CONFIG = 8'h52;
    localparam logic [7:0] FC_PSU_FAULTY = 8'h55;
    localparam logic [7:0] FC_PSU_UNKNOWN = 8'h56;
    localparam logic [7:0] FC_HW_CONFIG = 8'h5A;
    localparam logic [7:0] FC_COMM_UNKNOWN = 8'h5F;
    localparam logic [7:0] FC_PROTO_CFG = 8'h68;
    localparam logic [7:0] FC_VREF_0 = 8'h83;
    localparam logic [7:0] FC_VREF_1 = 8'h8B;
    localparam logic [7:0] FC_VREF_2 = 8'hC3;
    localparam logic [7:0] FC_VREF_3 = 8'hCB;
    localparam logic [7:0] FC_VREF_4 = 8'hDE;
    localparam logic [7:0] FC_VREF_5 = 8'hDF;
    localparam logic [7:0] FC_MEAS_UNIT = 8'hFD;
    // default restart confirm time and blink half period
    localparam int RESTART_NS = 4000;
    localparam int BLINK_HALF_NS = 1000;
    localparam int CLK_NS = 4;
    localparam int RESTART_CYC = RESTART_NS / CLK_NS;
    localparam int BLINK_CYC = BLINK_HALF_NS / CLK_NS;
    // display message source
    typedef enum logic [1:0] {
        EMFS_DISP_NONE,
        EMFS_DISP_WARN,
        EMFS_DISP_FAULT
    } emfs_disp_t;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } emfs_req_t;
endpackage

// file: src/emfs_top.sv
// event mask filtering and internal fault supervision for the relay core
// assumes one clock; event inputs and fault inputs are synchronous to i_mclk
// What this block does
// - output mask: five outputs, default first pair
// - input mask: five inputs, default all off
// - stage a: alarm 1/2, trip 4/8
// - stage b: alarm 16/32, trip 64/128
// - thermal mask defaults to zero
// - supervise always, show fault on light, display
// - two classes: blocking fault or warning
// - restart first, escalate only if persistent
// - persistent fault: ready blinks, supervision contact on
// - other contacts reset and locked during fault
// - display fault message with numeric code
// - fault message has top display priority
// - no clearing while ready light blinks
// - fault gone: stop blink, keep message
// - codes 4 to 8 name failed relay
// - code 9 enable, 10 to 12 feedback
// - supply, program, work, parameter memory codes
// - parameter memory fault forces settings zero
// - codes 75 to 82 sensor module faults
// - codes 85, 86, 90, 95 modules, config
// - code 104 protocol configuration set fault
// - reference voltage codes, 253 measuring unit
//
// The placing of the registers and the strobed register port were chosen for this implementation.

// overview
// three masks gate the raw event strobes
// a set mask bit admits its event
// admitted events set sticky flags
// flags stay until software clears them
// one fault level drives supervision
// a new fault first gets a restart
// only a lasting fault escalates
// escalation blinks ready, opens contacts
// and pulls in the supervision contact
// the fault code is latched for display
// warnings never escalate or latch
// inputs are synchronous to i_mclk
// every output leaves from a flop

// limits a user must know
// restart and blink counts are in cycles
// so they must match the clock in use
// a code change in a fault shows live
// a warning and a persistent fault show the fault
// clear is refused while fault persists
// and taken at once after it
// flags have no overflow indication
module emfs_top
    import emfs_pkg::*;
#(
    parameter int RESTART_CYCLES = RESTART_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // register port
    input wire emfs_pkg::emfs_req_t i_req,
    output logic [15:0] o_rdata,
    // raw event strobes: outputs (act/reset pairs), inputs, thermal
    input wire logic [9:0] i_out_evt,
    input wire logic [9:0] i_din_evt,
    input wire logic [7:0] i_thm_evt,
    // supervision inputs
    input wire logic i_fault,
    input wire logic [7:0] i_fault_code,
    input wire logic i_warning,
    input wire logic i_startup,
    input wire logic [4:0] i_contact_req,
    // supervision outputs
    output logic o_restart,
    output logic o_ready_led,
    output logic o_supv_contact,
    output logic [4:0] o_contact,
    output logic o_settings_zero,
    output emfs_pkg::emfs_disp_t o_disp_src,
    output logic [7:0] o_disp_code,
    // filtered event report
    output logic [27:0] o_evt
);
    import emfs_pkg::*;

    // supervision states
    // ok: no fault, contacts follow
    // restart: restart attempt running
    // persist: fault outlived attempt
    // codes are left to the tool
    typedef enum logic [1:0] {
        EMFS_ST_OK,
        EMFS_ST_RESTART,
        EMFS_ST_PERSIST
    } emfs_state_t;

    // counters are 32 bits so any
    // restart or blink count fits
    emfs_state_t state_q; // supervision state
    logic [9:0] out_mask_q; // output contact event mask
    logic [9:0] din_mask_q; // digital input event mask
    logic [7:0] thm_mask_q; // thermal stage event mask
    logic [27:0] evt_q; // sticky masked events
    logic [27:0] evt_raw; // all raw events joined
    logic [27:0] mask_all; // all masks joined
    logic [31:0] rst_cnt_q; // restart confirm counter
    logic [31:0] blink_cnt_q; // blink half-period counter
    logic blink_q; // blink phase
    logic msg_q; // fault message latched
    logic [7:0] code_q; // latched fault code
    logic param_fault; // general parameter memory fault
    logic wr_ctl; // control register write
    logic [15:0] status; // status word

    // events and masks join in one order
    // so one index picks strobe and bit
    // bits 0 to 9: output contact pairs
    // bits 10 to 19: digital input pairs
    // bits 20 to 27: thermal stages
    // the control write is decoded once
    // for both clear bits

    assign evt_raw = {i_thm_evt, i_din_evt, i_out_evt};
    assign mask_all = {thm_mask_q, din_mask_q, out_mask_q};
    assign wr_ctl = i_req.wr && (i_req.addr == ADDR_CONTROL);

    // settings go to zero only for the
    // general parameter memory codes
    // the calibration code is separate
    // and leaves the settings alone

    // general parameter memory codes, calibration code excluded
    assign param_fault = i_fault && (i_fault_code >= FC_PARAM_LO)
        && (i_fault_code <= FC_PARAM_HI) && (i_fault_code != FC_PARAM_CAL);

    // one write strobe serves all masks
    // other indices leave them alone
    // reset enables only the first pair
    // only low bits of the word are kept

    // mask registers written from software
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            out_mask_q <= OUT_MASK_RST;
            din_mask_q <= DIN_MASK_RST;
            thm_mask_q <= THM_MASK_RST;
        end else if (i_req.wr) begin
            case (i_req.addr)
                ADDR_OUT_MASK: out_mask_q <= i_req.wdata[9:0];
                ADDR_DIN_MASK: din_mask_q <= i_req.wdata[9:0];
                ADDR_THM_MASK: thm_mask_q <= i_req.wdata[7:0];
                default: ;
            endcase
        end
    end

    // each of the 28 flags has a process
    // an event beside a clear wins, so
    // no event is lost to a racing clear
    // a held strobe keeps its flag set
    // clearing is all flags at once

    // sticky event capture, one bit per weight; set beats clear
    genvar g;
    generate
        for (g = 0; g < 28; g++) begin : g_evt
            always_ff @(posedge i_mclk) begin
                if (!i_rstn) begin
                    evt_q[g] <= 1'b0;
                end else if (evt_raw[g] && mask_all[g]) begin
                    evt_q[g] <= 1'b1;
                end else if (wr_ctl && i_req.wdata[CTL_CLEAR_EVT]) begin
                    evt_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // the attempt lasts RESTART_CYCLES
    // edges of a fault still present
    // a fault gone in the attempt
    // returns to ok with no trace
    // the counter clears in ok, so each
    // new fault gets a full attempt
    // persist leaves only when fault clears
    // an unknown state falls back to ok

    // supervision state: restart attempt, then persistence
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_q <= EMFS_ST_OK;
            rst_cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                EMFS_ST_OK: begin
                    rst_cnt_q <= 32'h0000_0000;
                    if (i_fault) begin
                        state_q <= EMFS_ST_RESTART;
                    end
                end
                EMFS_ST_RESTART: begin
                    if (!i_fault) begin
                        state_q <= EMFS_ST_OK; // restart cured it
                    end else if (rst_cnt_q >= 32'(RESTART_CYCLES - 1)) begin
                        state_q <= EMFS_ST_PERSIST;
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
                    end
                end
                EMFS_ST_PERSIST: begin
                    if (!i_fault) begin
                        state_q <= EMFS_ST_OK;
                    end
                end
                default: state_q <= EMFS_ST_OK;
            endcase
        end
    end

    // the counter restarts outside persist
    // so each blink starts in one phase
    // first led value in persist is dark
    // so the change shows at once
    // half period is BLINK_CYCLES edges

    // blink timer runs only while the fault persists
    always_ff @(posedge i_mclk) begin
        if (!i_rstn || state_q != EMFS_ST_PERSIST) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q <= 1'b0;
        end else if (blink_cnt_q >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
        end
    end

    // the message is refreshed in every
    // persist cycle, so a clear write
    // or a start-up there is a no-op
    // after the fault the code stays
    // until cleared or a start begins
    // the code reads zero once cleared

    // fault message latch: clear refused while blinking
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            msg_q <= 1'b0;
            code_q <= FC_NONE;
        end else if (state_q == EMFS_ST_PERSIST) begin
            msg_q <= 1'b1;
            code_q <= i_fault_code;
        end else if (i_startup || (wr_ctl && i_req.wdata[CTL_CLEAR_MSG])) begin
            msg_q <= 1'b0;
            code_q <= FC_NONE;
        end
    end

    // ready is steady outside persist
    // and follows the blink phase inside
    // contacts are open and locked in
    // persist; requests are ignored
    // else contacts follow one cycle late
    // restart is a level for the attempt
    // ready is dark in reset

    // indicators and contacts
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_ready_led <= 1'b0;
            o_supv_contact <= 1'b0;
            o_contact <= 5'h00;
            o_restart <= 1'b0;
            o_settings_zero <= 1'b0;
        end else begin
            o_restart <= (state_q == EMFS_ST_RESTART);
            o_ready_led <= (state_q == EMFS_ST_PERSIST) ? blink_q : 1'b1;
            o_supv_contact <= (state_q == EMFS_ST_PERSIST);
            o_contact <= (state_q == EMFS_ST_PERSIST) ? 5'h00 : i_contact_req;
            o_settings_zero <= param_fault;
        end
    end

    // a kept message or a persistent fault
    // always beats a warning
    // live code shows during the fault
    // the latched code shows after it
    // a warning shows with no code

    // display source: fault message outranks warnings
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_disp_src <= EMFS_DISP_NONE;
            o_disp_code <= FC_NONE;
        end else if (msg_q || state_q == EMFS_ST_PERSIST) begin
            o_disp_src <= EMFS_DISP_FAULT;
            o_disp_code <= (state_q == EMFS_ST_PERSIST) ? i_fault_code : code_q;
        end else if (i_warning) begin
            o_disp_src <= EMFS_DISP_WARN;
            o_disp_code <= FC_NONE;
        end else begin
            o_disp_src <= EMFS_DISP_NONE;
            o_disp_code <= FC_NONE;
        end
    end

    // bit 0 raw fault, bit 1 persist
    // bit 2 message, bit 3 restarting
    // bit 4 warning, bit 5 settings zero
    // other bits read zero

    // status word
    always_comb begin
        status = 16'h0000;
        status[STS_FAULT_ACTIVE] = i_fault;
        status[STS_BLINK] = (state_q == EMFS_ST_PERSIST);
        status[STS_MSG_SHOWN] = msg_q;
        status[STS_RESTARTING] = (state_q == EMFS_ST_RESTART);
        status[STS_WARNING] = i_warning;
        status[STS_SETTINGS_ZERO] = o_settings_zero;
    end

    // data stand one cycle, then zero,
    // so a stale word never looks fresh
    // index 5 reads upper event flags
    // beside low input mask bits
    // unmapped indices read zero
    // the port never makes anyone wait

    // read data, one cycle after the read strobe
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (i_req.rd) begin
            case (i_req.addr)
                ADDR_OUT_MASK: o_rdata <= {6'h00, out_mask_q};
                ADDR_DIN_MASK: o_rdata <= {6'h00, din_mask_q};
                ADDR_THM_MASK: o_rdata <= {8'h00, thm_mask_q};
                ADDR_STATUS: o_rdata <= status;
                ADDR_EVENTS: o_rdata <= {6'h00, evt_q[9:0]};
                ADDR_CONTROL: o_rdata <= {din_mask_q[5:0], evt_q[27:18]};
                ADDR_FAULT_CODE: o_rdata <= {8'h00, code_q};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // flags mirrored one cycle late
    // for a reader that polls no register

    // event output mirrors the sticky flags
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_evt <= 28'h000_0000;
        end else begin
            o_evt <= evt_q;
        end
    end
endmodule
